/* File: rspm_mem_model.sv */
module rspm_mem_model (
    // clock
    input  wire logic        clk_sys,
    // pins as driven by the device
    input  wire logic [15:0] addr_out,
    input  wire logic [15:0] addr_oe,
    input  wire logic [7:0]  data_out,
    input  wire logic [7:0]  data_oe,
    // board strap resistors on address pins 3..0
    input  wire logic [3:0]  strap_level,
    // resolved pin levels back to the device
    output logic      [3:0]  addr_in,
    output logic      [7:0]  data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:255];
    logic       mem_sel;

    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end

    always @(posedge clk_sys) begin
        if (data_oe == 8'hff) begin
            mem[addr_out[7:0]] <= data_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // straps are stronger than the weak internal pulls, only legal codes used
    assign addr_in = (addr_oe[3:0] & addr_out[3:0]) | (~addr_oe[3:0] & strap_level);

    // memory answers only while address pins 15..3 are driven and data pins released; driven data pins read back as driven, else pull-up level
    assign mem_sel = (addr_oe[15:3] == 13'h1fff) && (data_oe == 8'h00);
    assign data_in = (data_oe != 8'h00) ? data_out : (mem_sel ? mem[addr_out[7:0]] : 8'hff);
endmodule

/* File: rspm_pkg.sv */
package rspm_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] RSPM_OFS_CTRL   = 8'h00;
    localparam logic [7:0] RSPM_OFS_STATUS = 8'h04;

    // control register fields
    localparam int RSPM_CTRL_IDLE_BIT    = 0;
    localparam int RSPM_CTRL_SLEEP_BIT   = 1;
    localparam int RSPM_CTRL_ROM_DIS_BIT = 2;

    // status register fields
    localparam int RSPM_ST_FREQ_LSB     = 0;
    localparam int RSPM_ST_DRV_BIT      = 2;
    localparam int RSPM_ST_IRPOL_BIT    = 3;
    localparam int RSPM_ST_RSVD_BIT     = 4;
    localparam int RSPM_ST_PINRST_BIT   = 5;

    // reset values
    localparam logic       RSPM_RST_IDLE    = 1'b0;
    localparam logic       RSPM_RST_SLEEP   = 1'b0;
    localparam logic       RSPM_RST_ROM_DIS = 1'b1;
    localparam logic [1:0] RSPM_RST_FREQ    = 2'h0;
    localparam logic       RSPM_RST_DRV     = 1'b0;
    localparam logic       RSPM_RST_IRPOL   = 1'b1;

    // clock frequency strap codes
    localparam logic [1:0] RSPM_FREQ_24 = 2'h0;
    localparam logic [1:0] RSPM_FREQ_48 = 2'h3;

    // clock drive mode strap values
    localparam logic RSPM_DRV_CRYSTAL  = 1'b0;
    localparam logic RSPM_DRV_EXTERNAL = 1'b1;

    // synchroniser layout
    localparam int RSPM_SYNC_W      = 14;
    localparam int RSPM_SYNC_ADDR   = 0;
    localparam int RSPM_SYNC_NRST   = 4;
    localparam int RSPM_SYNC_INTERRUPT_INPUT_TWO   = 5;
    localparam int RSPM_SYNC_DATA   = 6;
    localparam int RSPM_SYNC_STAGES = 2;

    // clocking
    localparam int RSPM_CLK_PERIOD_NS = 100;

endpackage

/* File: rspm_sync.sv */
module rspm_sync
    import rspm_pkg::*;
#(
    parameter int WIDTH = RSPM_SYNC_W
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] next_stage_one;
    logic [WIDTH-1:0] next_sync_out;

    // first stage is read only by the second stage
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_comb begin
                next_stage_one[gi] = async_in[gi];
                next_sync_out[gi]  = stage_one[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= next_stage_one;
            sync_out  <= next_sync_out;
        end
    end

endmodule

/* File: rspm_top.sv */
//
// Behaviour
// - sample address pins 3..0, latch at reset release
// - pin 3 pulled up, latched as led polarity
// - pin 2 pulled down, latched as drive mode
// - mode 0 crystal 24MHz, 1 external clock
// - external mode: idle, no interrupt_input_two, sleep float pin2
// - crystal mode: pin 2 acts as address
// - data pins used only when rom disable zero
// - upper pins carry processor fetch address
// - pins 1..0 pick 24 or 48MHz in external mode
//
module rspm_top
    import rspm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // device reset pin and interrupt pin
    input  wire logic        reset_in_active_low,
    input  wire logic        interrupt_input_two,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // processor side of the program memory port
    input  wire logic [15:0] cpu_mem_addr,
    input  wire logic [7:0]  cpu_mem_wdata,
    input  wire logic        cpu_mem_wr,
    output logic      [7:0]  cpu_mem_rdata,
    // program memory address pins (3..0 are shared with straps)
    input  wire logic [3:0]  prog_mem_addr_in,
    output logic      [15:0] prog_mem_addr_out,
    output logic      [15:0] prog_mem_addr_oe,
    output logic             ir_led_polarity_pullup_en,
    output logic      [2:0]  strap_pulldown_en,
    // program memory data pins
    input  wire logic [7:0]  prog_mem_data_in,
    output logic      [7:0]  prog_mem_data_out,
    output logic      [7:0]  prog_mem_data_oe,
    output logic             prog_mem_data_pullup_en,
    // latched strap results
    output logic             ir_led_polarity_strap,
    output logic             clock_drive_mode_strap,
    output logic      [1:0]  clock_freq_strap,
    output logic             clock_select_48
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers

    logic [RSPM_SYNC_W-1:0]      sync_q;
    logic [RSPM_SYNC_STAGES-1:0] sync_fill;
    logic [RSPM_SYNC_STAGES-1:0] next_sync_fill;
    logic                        pin_rst;
    logic                        interrupt_input_two_sync;
    logic [3:0]                  addr_sync;
    logic [7:0]                  data_sync;

    rspm_sync #(
        .WIDTH (RSPM_SYNC_W)
    ) u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in ({prog_mem_data_in, interrupt_input_two, reset_in_active_low, prog_mem_addr_in}),
        .sync_out (sync_q)
    );

    // synchroniser zeros would look like a held reset pin and latch zero straps,
    // so the pin reset only counts once both stages hold real samples
    always_comb begin
        next_sync_fill = {sync_fill[RSPM_SYNC_STAGES-2:0], 1'b1};
        addr_sync      = sync_q[RSPM_SYNC_ADDR +: 4];
        pin_rst        = sync_fill[RSPM_SYNC_STAGES-1] && !sync_q[RSPM_SYNC_NRST];
        interrupt_input_two_sync      = sync_q[RSPM_SYNC_INTERRUPT_INPUT_TWO];
        data_sync      = sync_q[RSPM_SYNC_DATA +: 8];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync_fill <= '0;
        end else begin
            sync_fill <= next_sync_fill;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap capture

    logic       next_irpol;
    logic       next_drv;
    logic [1:0] next_freq;
    logic       next_sel48;
    logic       freq_reserved;

    always_comb begin
        next_irpol = ir_led_polarity_strap;
        next_drv   = clock_drive_mode_strap;
        next_freq  = clock_freq_strap;
        // follow the pins while held, the last sample is what stays
        if (pin_rst) begin
            next_freq  = addr_sync[1:0];
            next_drv   = addr_sync[2];
            next_irpol = addr_sync[3];
        end
        // reserved codes fall back to 24MHz rather than guess
        next_sel48    = (next_drv == RSPM_DRV_EXTERNAL) && (next_freq == RSPM_FREQ_48);
        freq_reserved = (clock_freq_strap != RSPM_FREQ_24) && (clock_freq_strap != RSPM_FREQ_48);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ir_led_polarity_strap  <= RSPM_RST_IRPOL;
            clock_drive_mode_strap <= RSPM_RST_DRV;
            clock_freq_strap       <= RSPM_RST_FREQ;
            clock_select_48        <= 1'b0;
        end else begin
            ir_led_polarity_strap  <= next_irpol;
            clock_drive_mode_strap <= next_drv;
            clock_freq_strap       <= next_freq;
            clock_select_48        <= next_sel48;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers and register port

    logic        idle_bit;
    logic        sleep_bit;
    logic        rom_dis;
    logic        next_idle;
    logic        next_sleep;
    logic        next_rom_dis;
    logic [31:0] next_rdata;

    always_comb begin
        next_idle    = idle_bit;
        next_sleep   = sleep_bit;
        next_rom_dis = rom_dis;
        next_rdata   = 32'h0;
        if (reg_wr && reg_addr == RSPM_OFS_CTRL) begin
            next_idle    = reg_wdata[RSPM_CTRL_IDLE_BIT];
            next_sleep   = reg_wdata[RSPM_CTRL_SLEEP_BIT];
            next_rom_dis = reg_wdata[RSPM_CTRL_ROM_DIS_BIT];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                RSPM_OFS_CTRL: begin
                    next_rdata[RSPM_CTRL_IDLE_BIT]    = idle_bit;
                    next_rdata[RSPM_CTRL_SLEEP_BIT]   = sleep_bit;
                    next_rdata[RSPM_CTRL_ROM_DIS_BIT] = rom_dis;
                end
                RSPM_OFS_STATUS: begin
                    next_rdata[RSPM_ST_FREQ_LSB +: 2] = clock_freq_strap;
                    next_rdata[RSPM_ST_DRV_BIT]       = clock_drive_mode_strap;
                    next_rdata[RSPM_ST_IRPOL_BIT]     = ir_led_polarity_strap;
                    next_rdata[RSPM_ST_RSVD_BIT]      = freq_reserved;
                    next_rdata[RSPM_ST_PINRST_BIT]    = pin_rst;
                end
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            idle_bit  <= RSPM_RST_IDLE;
            sleep_bit <= RSPM_RST_SLEEP;
            rom_dis   <= RSPM_RST_ROM_DIS;
            reg_rdata <= 32'h0;
        end else begin
            idle_bit  <= next_idle;
            sleep_bit <= next_sleep;
            rom_dis   <= next_rom_dis;
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive

    logic        pin2_float;
    logic [15:0] next_addr_out;
    logic [15:0] next_addr_oe;
    logic        next_pu3;
    logic [2:0]  next_pd;
    logic [7:0]  next_data_out;
    logic [7:0]  next_data_oe;
    logic [7:0]  next_cpu_rdata;

    always_comb begin
        pin2_float    = (clock_drive_mode_strap == RSPM_DRV_EXTERNAL) && idle_bit
                        && !interrupt_input_two_sync && sleep_bit;
        next_addr_out = cpu_mem_addr;
        next_addr_oe  = 16'hffff;
        if (pin2_float) begin
            next_addr_oe[2] = 1'b0;
        end
        next_pu3      = pin_rst;
        next_pd       = {3{pin_rst}};
        next_data_out = cpu_mem_wdata;
        next_data_oe  = {8{!rom_dis && cpu_mem_wr}};
        next_cpu_rdata = rom_dis ? 8'h0 : data_sync;
        // keep off the shared pins so only the strap resistors set them
        if (pin_rst) begin
            next_addr_oe = 16'h0;
            next_data_oe = 8'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prog_mem_addr_out         <= 16'h0;
            prog_mem_addr_oe          <= 16'h0;
            ir_led_polarity_pullup_en <= 1'b1;
            strap_pulldown_en         <= 3'h7;
            prog_mem_data_out         <= 8'h0;
            prog_mem_data_oe          <= 8'h0;
            prog_mem_data_pullup_en   <= 1'b1;
            cpu_mem_rdata             <= 8'h0;
        end else begin
            prog_mem_addr_out         <= next_addr_out;
            prog_mem_addr_oe          <= next_addr_oe;
            ir_led_polarity_pullup_en <= next_pu3;
            strap_pulldown_en         <= next_pd;
            prog_mem_data_out         <= next_data_out;
            prog_mem_data_oe          <= next_data_oe;
            prog_mem_data_pullup_en   <= 1'b1;
            cpu_mem_rdata             <= next_cpu_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_strap_sample;
        pin_rst |=> clock_freq_strap == $past(addr_sync[1:0]);
    endproperty
    a_strap_sample: assert property (p_strap_sample) else $error("freq strap not sampled");

    property p_irpol;
        pin_rst |=> ir_led_polarity_pullup_en && ir_led_polarity_strap == $past(addr_sync[3]);
    endproperty
    a_irpol: assert property (p_irpol) else $error("led polarity strap wrong");

    property p_drvmode;
        pin_rst |=> strap_pulldown_en == 3'h7 && clock_drive_mode_strap == $past(addr_sync[2]);
    endproperty
    a_drvmode: assert property (p_drvmode) else $error("drive mode strap wrong");

    property p_crystal_24;
        !clock_drive_mode_strap |=> !clock_select_48 || $past(pin_rst);
    endproperty
    a_crystal_24: assert property (p_crystal_24) else $error("48MHz in crystal mode");

    property p_float;
        clock_drive_mode_strap && idle_bit && !interrupt_input_two_sync && sleep_bit |=> !prog_mem_addr_oe[2];
    endproperty
    a_float: assert property (p_float) else $error("pin 2 not floated");

    property p_crystal_drive;
        !clock_drive_mode_strap && !pin_rst |=> prog_mem_addr_oe[2] && prog_mem_addr_out[2] == $past(cpu_mem_addr[2]);
    endproperty
    a_crystal_drive: assert property (p_crystal_drive) else $error("pin 2 not driven");

    property p_rom_gate;
        rom_dis |=> prog_mem_data_oe == 8'h0 ##1 cpu_mem_rdata == 8'h0 || !$past(rom_dis);
    endproperty
    a_rom_gate: assert property (p_rom_gate) else $error("data pins used while disabled");

    property p_upper_addr;
        !pin_rst |=> prog_mem_addr_out[15:3] == $past(cpu_mem_addr[15:3]) && &prog_mem_addr_oe[15:3];
    endproperty
    a_upper_addr: assert property (p_upper_addr) else $error("upper address wrong");

    property p_hold;
        !pin_rst ##1 !pin_rst |-> $stable(clock_freq_strap) && $stable(clock_drive_mode_strap)
                                  && $stable(ir_led_polarity_strap);
    endproperty
    a_hold: assert property (p_hold) else $error("strap changed outside reset");

    property p_undriven;
        pin_rst |=> prog_mem_addr_oe == 16'h0;
    endproperty
    a_undriven: assert property (p_undriven) else $error("address driven in pin reset");

endmodule

/* File: tb_top.sv */
module tb_top
    import rspm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys = 1'b0;
    logic        reset;
    logic        reset_in_active_low;
    logic        interrupt_input_two;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [15:0] cpu_mem_addr;
    logic [7:0]  cpu_mem_wdata;
    logic        cpu_mem_wr;
    logic [7:0]  cpu_mem_rdata;
    logic [3:0]  addr_in;
    logic [15:0] addr_out;
    logic [15:0] addr_oe;
    logic        pol_pu;
    logic [2:0]  pd_en;
    logic [7:0]  data_in;
    logic [7:0]  data_out;
    logic [7:0]  data_oe;
    logic        data_pu;
    logic        pol_s;
    logic        drv_s;
    logic [1:0]  freq_s;
    logic        sel48;
    logic [3:0]  strap_level;
    logic [31:0] rd;
    int          fail_count = 0;
    int          total_checks = 0;

    always #50 clk_sys = ~clk_sys;

    rspm_top DUT (.clk_sys(clk_sys), .reset(reset), .reset_in_active_low(reset_in_active_low),
        .interrupt_input_two(interrupt_input_two), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_mem_addr(cpu_mem_addr),
        .cpu_mem_wdata(cpu_mem_wdata), .cpu_mem_wr(cpu_mem_wr), .cpu_mem_rdata(cpu_mem_rdata),
        .prog_mem_addr_in(addr_in), .prog_mem_addr_out(addr_out), .prog_mem_addr_oe(addr_oe),
        .ir_led_polarity_pullup_en(pol_pu), .strap_pulldown_en(pd_en), .prog_mem_data_in(data_in),
        .prog_mem_data_out(data_out), .prog_mem_data_oe(data_oe), .prog_mem_data_pullup_en(data_pu),
        .ir_led_polarity_strap(pol_s), .clock_drive_mode_strap(drv_s), .clock_freq_strap(freq_s),
        .clock_select_48(sel48));

    rspm_mem_model partner (.clk_sys(clk_sys), .addr_out(addr_out), .addr_oe(addr_oe),
        .data_out(data_out), .data_oe(data_oe), .strap_level(strap_level), .addr_in(addr_in),
        .data_in(data_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic check_val(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // read data is valid only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset_regs();
        reg_read(RSPM_OFS_CTRL, rd);
        check_val("ctrl", rd, 32'h4);
        reg_read(RSPM_OFS_STATUS, rd);
        check_val("status", rd, 32'h8);
        reg_write(8'h08, 32'hffffffff);
        reg_read(8'h08, rd);
        check_val("unmapped", rd, 32'h0);
        reg_read(RSPM_OFS_CTRL, rd);
        check_val("ctrl kept", rd, 32'h4);
        check_val("data pullup", 32'(data_pu), 32'h1);
    endtask

    task automatic test_strap(input logic pol, input logic drv, input logic [1:0] freq);
        @(posedge clk_sys);
        strap_level <= {pol, drv, freq};
        reset_in_active_low <= 1'b0;
        cyc(6);
        check_val("addr_oe in reset", 32'(addr_oe), 32'h0);
        check_val("pullup", 32'(pol_pu), 32'h1);
        check_val("pulldown", 32'(pd_en), 32'h7);
        reg_read(RSPM_OFS_STATUS, rd);
        check_val("status in reset", rd, {26'h0, 2'b10, pol, drv, freq});
        @(posedge clk_sys);
        reset_in_active_low <= 1'b1;
        cpu_mem_addr <= 16'h000f;
        cyc(6);
        check_val("pol strap", 32'(pol_s), 32'(pol));
        check_val("drv strap", 32'(drv_s), 32'(drv));
        check_val("freq strap", 32'(freq_s), 32'(freq));
        check_val("sel48", 32'(sel48), 32'(drv && freq == RSPM_FREQ_48));
        check_val("pulls off", 32'({pol_pu, pd_en}), 32'h0);
        check_val("addr_oe", 32'(addr_oe), 32'hffff);
        check_val("addr_out", 32'(addr_out), 32'h000f);
        // board straps flipped after latch must have no effect
        @(posedge clk_sys);
        strap_level <= ~{pol, drv, freq};
        reg_write(RSPM_OFS_CTRL, 32'h7);
        cyc(6);
        check_val("pin2 sleep", 32'(addr_oe[2]), 32'(!drv));
        check_val("pin3 sleep", 32'(addr_oe[3]), 32'h1);
        @(posedge clk_sys);
        interrupt_input_two <= 1'b1;
        cyc(6);
        check_val("pin2 interrupt_input_two", 32'(addr_oe[2]), 32'h1);
        reg_write(RSPM_OFS_CTRL, 32'h5);
        @(posedge clk_sys);
        interrupt_input_two <= 1'b0;
        cyc(6);
        check_val("pin2 awake", 32'(addr_oe[2]), 32'h1);
        check_val("straps held", 32'({pol_s, drv_s, freq_s}), 32'({pol, drv, freq}));
        reg_write(RSPM_OFS_CTRL, 32'h4);
    endtask

    task automatic test_memory();
        reg_write(RSPM_OFS_CTRL, 32'h0);
        @(posedge clk_sys);
        cpu_mem_addr <= 16'h1234;
        cyc(6);
        check_val("fetch addr", 32'(addr_out), 32'h1234);
        check_val("fetch oe", 32'(data_oe), 32'h0);
        check_val("fetch data", 32'(cpu_mem_rdata), 32'(8'h34 ^ 8'h5a));
        @(posedge clk_sys);
        cpu_mem_wr <= 1'b1;
        cpu_mem_wdata <= 8'ha5;
        cyc(2);
        check_val("write oe", 32'(data_oe), 32'hff);
        check_val("write data", 32'(data_out), 32'ha5);
        @(posedge clk_sys);
        cpu_mem_wr <= 1'b0;
        cyc(6);
        check_val("read back", 32'(cpu_mem_rdata), 32'ha5);
        reg_write(RSPM_OFS_CTRL, 32'h4);
        @(posedge clk_sys);
        cpu_mem_wr <= 1'b1;
        cyc(6);
        check_val("rom off oe", 32'(data_oe), 32'h0);
        check_val("rom off data", 32'(cpu_mem_rdata), 32'h0);
        @(posedge clk_sys);
        cpu_mem_wr <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        reset_in_active_low = 1'b1;
        interrupt_input_two = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {cpu_mem_addr, cpu_mem_wdata, cpu_mem_wr} = '0;
        strap_level = 4'h8;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        cyc(4);
        test_reset_regs();
        test_strap(1'b1, 1'b0, RSPM_FREQ_24);
        test_strap(1'b0, 1'b1, RSPM_FREQ_48);
        test_strap(1'b1, 1'b1, RSPM_FREQ_24);
        test_memory();
        final_report();
    end

    // the whole sequence takes well under a thousand cycles
    initial begin
        #500000;
        fail_count++;
        final_report();
    end
endmodule
